// file: double_slot_keystream_mapper.sv
// Double-slot key stream to tail and B-field bit mapper, one bearer
// ============================================================================
// Notes on behaviour
// [RULE_01] Unprotected B-field: all 800 bits are data
// [RULE_02] Multisubfield: 64 data then 16 check bits
// [RULE_03] Single subfield: 768 data, 32 check, 4 X
// [RULE_04] Check bits and X-field pass unencrypted
// [RULE_05] Two 840-bit segments per D-field pair
// [RULE_06] Control tail: key bits 0-39 onto a8-a47
// [RULE_07] Other tail: key bits 0-39 discarded
// [RULE_08] Unprotected: key bits 40-839 onto b0-b799
// [RULE_09] Single: key 40-807 onto b0-b767, rest unused
// [RULE_10] Subfield k: key 40+80k onto b(80k), 64 bits
// [RULE_11] Sixteen key bits after each subfield unused
// [RULE_12] Frame consumes 1680 key bits, full-slot sync
// [RULE_13] Per bearer, value from frame and multiframe
// [RULE_14] First D-field first segment, second next
// [RULE_15] Mode switch applies to whole connection
// [RULE_16] All connections of a call share mode
// [RULE_17] Mode indication and confirmation once per connection
// [RULE_18] Receive uses identical mapping to recover plaintext
module double_slot_keystream_mapper (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic frame_start, // Pulse before a frame's first bit
  input wire logic [ks_map_pkg::FN_W-1:0] frame_number, // With frame_start
  input wire logic [ks_map_pkg::MFN_W-1:0] multiframe_number, // Same
  input wire logic tail_is_control, // Tail carries control data
  input wire ks_map_pkg::bfield_format_t bfield_format, // B-field format
  input wire logic mode_req, // Pulse: new connection mode
  input wire logic mode_req_value, // 1 encrypt, 0 clear
  input wire logic mode_req_local, // Request raised by this end
  input wire logic ks_valid, // Key stream bit offered
  input wire logic ks_bit, // Key stream bit
  output logic ks_ready, // Key stream bit taken
  input wire logic in_valid, // Burst bit offered
  input wire logic in_bit, // Tail or B-field bit
  output logic in_ready, // Burst bit taken
  output logic out_valid, // Mapped bit available
  output logic out_bit, // Mapped bit
  output logic out_encrypted, // Key bit was applied
  output logic out_second_segment, // Bit of second D-field
  input wire logic out_ready, // Receiver takes mapped bit
  output logic [ks_map_pkg::IV_W-1:0] initialization_value, // Bearer value
  output logic encryption_mode_indication, // Pulse: peer mode change
  output logic encryption_mode_confirmation, // Pulse: own mode change
  output logic encryption_active, // Connection in encrypt mode
  output logic ks_sync_error // Sticky: frame key count wrong
);
  import ks_map_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    map_state_t state;
    logic [POS_W-1:0] pos;
    logic [SUB_W-1:0] sub_pos;
    logic second_seg;
    logic [FRAME_W-1:0] frame_ks;
    logic ks_full;
    logic ks_hold;
    logic ks_rdy;
    logic in_full;
    logic in_hold;
    logic in_rdy;
    logic tail_ct;
    bfield_format_t fmt;
    logic enc_mode;
    logic pend;
    logic pend_mode;
    logic pend_local;
    logic ind;
    logic cfm;
    logic sync_err;
    logic [IV_W-1:0] iv;
  } map_state_reg_t;

  map_state_reg_t st_reg;
  map_state_reg_t st_next;

  logic in_tail;
  logic in_ks_range;
  logic need_ks;
  logic key_mask;
  logic key_apply;
  logic pos_last;
  logic fire;
  logic ks_take;
  logic in_take;
  logic [WORD_W-1:0] buf_out;

  bit_stream_if #(.WIDTH(WORD_W)) map_if ();

  // ==========================================================================
  // Bit classification
  assign in_tail = (st_reg.pos < TAIL_LEN);
  assign in_ks_range = (st_reg.pos <= KS_LAST);
  // Clear mode: generator is not drained, burst bits pass straight
  assign need_ks = st_reg.enc_mode && in_ks_range; // [RULE_05]

  always_comb
  begin
    key_mask = 1'b0;
    if (in_tail)
    begin
      key_mask = st_reg.tail_ct; // [RULE_06] [RULE_07]
    end
    else
    begin
      case (st_reg.fmt)
        FMT_UNPROT: key_mask = in_ks_range; // [RULE_01] [RULE_08]
        FMT_SINGLE: key_mask = (st_reg.pos < SINGLE_END); // [RULE_03] [RULE_09]
        FMT_MULTI: key_mask = in_ks_range &&
                              (st_reg.sub_pos < SUB_DATA_LEN); // [RULE_10] [RULE_11]
        default: key_mask = 1'b0;
      endcase
    end
  end

  // Check bits and X-field see no key bit; same path for receive
  assign key_apply = need_ks && key_mask; // [RULE_04] [RULE_18]
  assign pos_last = (st_reg.fmt == FMT_UNPROT) ? (st_reg.pos == KS_LAST)
                                               : (st_reg.pos == PROT_LAST);
  // Key bit is consumed even where unused, keeping positions aligned
  assign fire = (st_reg.state == ST_RUN) && st_reg.in_full &&
                (!need_ks || st_reg.ks_full) && map_if.ready; // [RULE_05]
  assign ks_take = ks_valid && st_reg.ks_rdy;
  assign in_take = in_valid && st_reg.in_rdy;

  assign map_if.valid = fire;
  assign map_if.data = {st_reg.second_seg, key_apply,
                        st_reg.in_hold ^ (key_apply & st_reg.ks_hold)};

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.ind = 1'b0;
    st_next.cfm = 1'b0;

    if (fire)
    begin
      st_next.in_full = 1'b0;
      if (need_ks)
      begin
        st_next.ks_full = 1'b0;
        st_next.frame_ks = st_reg.frame_ks + 11'h001; // [RULE_12]
      end
      if (pos_last)
      begin
        st_next.pos = '0;
        st_next.sub_pos = '0;
        st_next.second_seg = ~st_reg.second_seg; // [RULE_14]
        if (st_reg.second_seg)
        begin
          st_next.state = ST_WAIT;
        end
      end
      else
      begin
        st_next.pos = st_reg.pos + 10'h001;
        if (!in_tail)
        begin
          st_next.sub_pos = (st_reg.sub_pos == SUB_LAST) ? 7'h00
                            : st_reg.sub_pos + 7'h01; // [RULE_02] [RULE_10]
        end
      end
    end

    if (frame_start)
    begin
      // Mid-frame start resynchronises; held bits are stale
      st_next.state = ST_RUN;
      st_next.pos = '0;
      st_next.sub_pos = '0;
      st_next.second_seg = 1'b0; // [RULE_14]
      st_next.frame_ks = '0;
      st_next.ks_full = 1'b0;
      st_next.in_full = 1'b0;
      st_next.tail_ct = tail_is_control;
      st_next.fmt = bfield_format;
      st_next.iv = {multiframe_number, frame_number}; // [RULE_13]
      if (st_reg.enc_mode && (st_reg.frame_ks != '0) &&
          (st_reg.frame_ks != FRAME_KS_BITS))
      begin
        st_next.sync_err = 1'b1; // [RULE_12]
      end
      if (st_reg.pend)
      begin
        // One mode for every bearer of the connection and call
        st_next.enc_mode = st_reg.pend_mode; // [RULE_15] [RULE_16]
        st_next.pend = 1'b0;
        st_next.cfm = st_reg.pend_local; // [RULE_17]
        st_next.ind = ~st_reg.pend_local; // [RULE_17]
      end
    end

    // A request landing on the switching frame waits for the next one
    if (mode_req)
    begin
      st_next.pend = 1'b1; // [RULE_15]
      st_next.pend_mode = mode_req_value;
      st_next.pend_local = mode_req_local;
    end

    if (ks_take)
    begin
      st_next.ks_full = 1'b1;
      st_next.ks_hold = ks_bit;
    end
    if (in_take)
    begin
      st_next.in_full = 1'b1;
      st_next.in_hold = in_bit;
    end

    // One bit held per side costs half rate but keeps readies registered
    st_next.ks_rdy = !st_next.ks_full && st_next.enc_mode &&
                     (st_next.state == ST_RUN);
    st_next.in_rdy = !st_next.in_full && (st_next.state == ST_RUN);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_reg <= '0;
      st_reg.state <= ST_WAIT;
      st_reg.fmt <= FMT_UNPROT;
      st_reg.enc_mode <= MODE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Output buffer
  ks_two_entry_buffer #(.WIDTH(WORD_W)) out_buffer (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_side(map_if),
    .out_valid(out_valid),
    .out_data(buf_out),
    .out_ready(out_ready)
  );

  assign out_bit = buf_out[0];
  assign out_encrypted = buf_out[1];
  assign out_second_segment = buf_out[2];
  assign ks_ready = st_reg.ks_rdy;
  assign in_ready = st_reg.in_rdy;
  assign initialization_value = st_reg.iv;
  assign encryption_mode_indication = st_reg.ind;
  assign encryption_mode_confirmation = st_reg.cfm;
  assign encryption_active = st_reg.enc_mode;
  assign ks_sync_error = st_reg.sync_err;

  // ==========================================================================
  // Checks
  chk_tail_discard: assert property ( // [RULE_07]
    @(posedge ref_clk) disable iff (reset)
    (fire && in_tail && !st_reg.tail_ct) |->
      (!map_if.data[1] && (map_if.data[0] == st_reg.in_hold)))
    else $error("tail keyed without control data");

  chk_tail_keyed: assert property ( // [RULE_06]
    @(posedge ref_clk) disable iff (reset)
    (fire && in_tail && st_reg.tail_ct && st_reg.enc_mode) |->
      (map_if.data[0] == (st_reg.in_hold ^ st_reg.ks_hold)))
    else $error("control tail not keyed");

  chk_unprot_all: assert property ( // [RULE_08]
    @(posedge ref_clk) disable iff (reset)
    (fire && st_reg.enc_mode && !in_tail && in_ks_range &&
     (st_reg.fmt == FMT_UNPROT)) |-> key_apply)
    else $error("unprotected bit left clear");

  chk_single_tail: assert property ( // [RULE_09]
    @(posedge ref_clk) disable iff (reset)
    (fire && (st_reg.fmt == FMT_SINGLE) && (st_reg.pos >= SINGLE_END))
      |-> !key_apply)
    else $error("single subfield check or X keyed");

  chk_multi_gap: assert property ( // [RULE_11]
    @(posedge ref_clk) disable iff (reset)
    (fire && (st_reg.fmt == FMT_MULTI) && !in_tail &&
     (st_reg.sub_pos >= SUB_DATA_LEN)) |-> !key_apply)
    else $error("subfield check bits keyed");

  chk_sub_align: assert property ( // [RULE_10]
    @(posedge ref_clk) disable iff (reset)
    (fire && (st_reg.pos == TAIL_LEN)) |-> (st_reg.sub_pos == 7'h00))
    else $error("subfield count misaligned at b0");

  chk_seg_order: assert property ( // [RULE_14]
    @(posedge ref_clk) disable iff (reset)
    (fire && pos_last && !st_reg.second_seg && !frame_start) |=>
      (st_reg.second_seg && (st_reg.pos == '0)))
    else $error("second segment not selected");

  chk_frame_count: assert property ( // [RULE_12]
    @(posedge ref_clk) disable iff (reset)
    (fire && need_ks && pos_last && st_reg.second_seg && !frame_start &&
     (st_reg.frame_ks == FRAME_KS_BITS - 11'h001)) |=>
      (st_reg.frame_ks == FRAME_KS_BITS) && (st_reg.state == ST_WAIT))
    else $error("frame key count off");

  chk_mode_report: assert property ( // [RULE_17]
    @(posedge ref_clk) disable iff (reset)
    (st_reg.enc_mode != $past(st_reg.enc_mode)) |->
      ((st_reg.ind ^ st_reg.cfm) && $past(frame_start)))
    else $error("mode changed without single report");

  chk_report_pulse: assert property ( // [RULE_17]
    @(posedge ref_clk) disable iff (reset)
    (st_reg.ind || st_reg.cfm) |=> !(st_reg.ind || st_reg.cfm))
    else $error("mode report longer than one cycle");

endmodule // double_slot_keystream_mapper

// file: ks_map_pkg.sv
// Constants and types shared by the double-slot key stream mapper
package ks_map_pkg;

  // ==========================================================================
  // Widths
  localparam int POS_W = 10;
  localparam int SUB_W = 7;
  localparam int FRAME_W = 11;
  localparam int FN_W = 4;
  localparam int MFN_W = 24;
  localparam int IV_W = MFN_W + FN_W;
  localparam int WORD_W = 3;

  // ==========================================================================
  // D-field layout, counted in bit positions of one segment
  localparam logic [POS_W-1:0] SEG_LEN = 10'h348;
  localparam logic [POS_W-1:0] TAIL_LEN = 10'h028;
  localparam logic [POS_W-1:0] SINGLE_DATA_LEN = 10'h300;
  localparam logic [POS_W-1:0] XFIELD_LEN = 10'h004;
  localparam logic [POS_W-1:0] KS_LAST = SEG_LEN - 10'h001;
  localparam logic [POS_W-1:0] SINGLE_END = TAIL_LEN + SINGLE_DATA_LEN;
  localparam logic [POS_W-1:0] PROT_LAST = KS_LAST + XFIELD_LEN;

  // ==========================================================================
  // Multisubfield layout: 64 data bits then 16 check bits per subfield
  localparam logic [SUB_W-1:0] SUB_PERIOD = 7'h50;
  localparam logic [SUB_W-1:0] SUB_DATA_LEN = 7'h40;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_PERIOD - 7'h01;

  // ==========================================================================
  // Key stream bits per frame, both segments
  localparam logic [FRAME_W-1:0] FRAME_KS_BITS = 11'h690;

  // ==========================================================================
  // Reset values
  localparam logic MODE_RESET = 1'b0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    FMT_UNPROT = 2'b00,
    FMT_SINGLE = 2'b01,
    FMT_MULTI = 2'b10
  } bfield_format_t;

  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_RUN = 1'b1
  } map_state_t;

endpackage

// file: bit_stream_if.sv
// Valid/ready bit word carrier between the mapper and its output buffer
interface bit_stream_if #(parameter int WIDTH = 3);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // bit_stream_if

// file: ks_two_entry_buffer.sv
// Two-entry valid/ready buffer on the mapped data path
module ks_two_entry_buffer #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  bit_stream_if.snk in_side, // Words from the mapper
  output logic out_valid, // Word available
  output logic [WIDTH-1:0] out_data, // Oldest word
  input wire logic out_ready // Receiver takes the word
);

  typedef struct packed {
    logic [1:0] count;
    logic valid;
    logic [1:0][WIDTH-1:0] entry;
  } buf_state_t;

  buf_state_t st_reg;
  buf_state_t st_next;
  logic push;
  logic pop;

  // Full at two entries; the mapper stalls on this
  assign in_side.ready = (st_reg.count != 2'h2);
  assign push = in_side.valid && in_side.ready;
  assign pop = st_reg.valid && out_ready;
  assign out_valid = st_reg.valid;
  assign out_data = st_reg.entry[0];

  always_comb
  begin
    st_next = st_reg;
    if (pop)
    begin
      st_next.entry[0] = st_reg.entry[1];
      st_next.count = st_reg.count - 2'h1;
    end
    if (push)
    begin
      st_next.entry[st_next.count[0]] = in_side.data;
      st_next.count = st_next.count + 2'h1;
    end
    st_next.valid = (st_next.count != 2'h0);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule // ks_two_entry_buffer

// file: burst_peer_model.sv
// Peer burst receiver model: takes mapped bits, optionally stalling
module burst_peer_model (
  input wire logic ref_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic stall, // Slow acceptance, one word in eight
  input wire logic out_valid, // Mapped bit available
  input wire logic out_bit, // Mapped bit
  input wire logic out_encrypted, // Key bit applied
  input wire logic out_second_segment, // Bit of second D-field
  output logic out_ready // Word taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Capture
  logic [2:0] got_q[$];
  logic [2:0] tick_reg = 3'h0;
  initial out_ready = 1'b0;
  always @(posedge ref_clk)
  begin
    tick_reg <= tick_reg + 3'h1;
    if (reset)
      out_ready <= 1'b0;
    else
    begin
      // Arrival order kept, so D-field order shows to the bench
      if (out_valid && out_ready)
        got_q.push_back({out_bit, out_encrypted, out_second_segment});
      // Stalling lets the two-entry buffer fill and back-pressure
      out_ready <= !stall || tick_reg == 3'h0;
    end
  end
endmodule // burst_peer_model

// file: test_double_slot_keystream_mapper.sv
// Self-checking bench for the double-slot key stream mapper
module test_double_slot_keystream_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  import ks_map_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic frame_start = 1'b0;
  logic [FN_W-1:0] frame_number = 4'h0;
  logic [MFN_W-1:0] multiframe_number = 24'h000000;
  logic tail_is_control = 1'b0;
  bfield_format_t bfield_format = FMT_UNPROT;
  logic mode_req = 1'b0, mode_req_value = 1'b0, mode_req_local = 1'b0;
  logic ks_valid = 1'b0, ks_bit = 1'b0, in_valid = 1'b0, in_bit = 1'b0;
  logic stall = 1'b0;
  logic ks_ready, in_ready, out_valid, out_bit, out_encrypted;
  logic out_second_segment, out_ready, ind, cfm, active, sync_err;
  logic [IV_W-1:0] iv;
  int fails = 0, n_compared = 0, n_ind = 0, n_cfm = 0, n_take = 0;

  always #2 ref_clk = ~ref_clk;

  double_slot_keystream_mapper double_slot_keystream_mapper_inst (
    .ref_clk(ref_clk), .reset(reset), .frame_start(frame_start),
    .frame_number(frame_number), .multiframe_number(multiframe_number),
    .tail_is_control(tail_is_control), .bfield_format(bfield_format),
    .mode_req(mode_req), .mode_req_value(mode_req_value),
    .mode_req_local(mode_req_local), .ks_valid(ks_valid), .ks_bit(ks_bit),
    .ks_ready(ks_ready), .in_valid(in_valid), .in_bit(in_bit),
    .in_ready(in_ready), .out_valid(out_valid), .out_bit(out_bit),
    .out_encrypted(out_encrypted), .out_second_segment(out_second_segment),
    .out_ready(out_ready), .initialization_value(iv),
    .encryption_mode_indication(ind), .encryption_mode_confirmation(cfm),
    .encryption_active(active), .ks_sync_error(sync_err));

  burst_peer_model peer_inst (
    .ref_clk(ref_clk), .reset(reset), .stall(stall), .out_valid(out_valid),
    .out_bit(out_bit), .out_encrypted(out_encrypted),
    .out_second_segment(out_second_segment), .out_ready(out_ready));

  always @(posedge ref_clk)
  begin
    if (ind === 1'b1) n_ind++;
    if (cfm === 1'b1) n_cfm++;
    if (ks_valid && ks_ready === 1'b1) n_take++;
  end

  // ==========================================================================
  // Helpers
  function automatic logic ks_fn(int n);
    return n[0] ^ n[2] ^ n[5];
  endfunction

  function automatic logic in_fn(int n);
    return n[1] ^ n[3] ^ n[6];
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic feed_ks(int total);
    for (int n = 0; n < total; n++)
    begin
      ks_valid <= 1'b1;
      ks_bit <= ks_fn(n);
      do @(posedge ref_clk); while (ks_ready !== 1'b1);
    end
    ks_valid <= 1'b0;
  endtask

  task automatic feed_in(int total);
    for (int n = 0; n < total; n++)
    begin
      in_valid <= 1'b1;
      in_bit <= in_fn(n);
      do @(posedge ref_clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
  endtask

  task automatic set_mode(logic value, logic local_req);
    @(posedge ref_clk);
    mode_req <= 1'b1;
    mode_req_value <= value;
    mode_req_local <= local_req;
    @(posedge ref_clk);
    mode_req <= 1'b0;
  endtask

  // ==========================================================================
  // One frame: both D-fields, every position compared
  task automatic run_frame(bfield_format_t fmt, logic ctl, logic enc,
                           logic slow);
    int len, pos, kn, take0;
    logic [2:0] w;
    logic used;
    len = (fmt == FMT_UNPROT) ? 840 : 844;
    @(posedge ref_clk);
    frame_start <= 1'b1;
    tail_is_control <= ctl;
    bfield_format <= fmt;
    stall <= slow;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    take0 = n_take;
    peer_inst.got_q.delete();
    fork
      if (enc) feed_ks(1680);
      else ks_valid <= 1'b1;
      feed_in(2 * len);
    join
    while (peer_inst.got_q.size() < 2 * len) @(posedge ref_clk);
    ks_valid <= 1'b0;
    for (int j = 0; j < 2 * len; j++)
    begin
      w = peer_inst.got_q[j];
      pos = j % len;
      kn = (j / len) * 840 + pos;
      used = enc && (pos < 40 ? ctl : fmt == FMT_UNPROT ? pos < 840 :
             fmt == FMT_SINGLE ? pos < 808 :
             (pos < 840 && (pos - 40) % 80 < 64));
      check("out_bit", w[2], in_fn(j) ^ (used & ks_fn(kn)));
      check("out_encrypted", w[1], used);
      check("out_second_segment", w[0], j >= len);
    end
    check("key bits taken", n_take - take0, enc ? 1680 : 0);
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    frame_number <= 4'h3;
    multiframe_number <= 24'h00ABCD;
    set_mode(1'b1, 1'b1);
    run_frame(FMT_UNPROT, 1'b1, 1'b1, 1'b1);
    check("confirmations", n_cfm, 1);
    check("indications", n_ind, 0);
    check("active", active, 1'b1);
    check("iv", iv, {24'h00ABCD, 4'h3});
    frame_number <= 4'h4;
    run_frame(FMT_SINGLE, 1'b0, 1'b1, 1'b0);
    check("iv", iv, {24'h00ABCD, 4'h4});
    run_frame(FMT_MULTI, 1'b1, 1'b1, 1'b0);
    check("confirmations", n_cfm, 1);
    check("sync error", sync_err, 1'b0);
    set_mode(1'b0, 1'b0);
    run_frame(FMT_MULTI, 1'b1, 1'b0, 1'b0);
    check("indications", n_ind, 1);
    check("active", active, 1'b0);
    print_verdict();
  end

  initial
  begin
    #320000;
    fails++;
    $display("BAD watchdog expected done seen hang");
    print_verdict();
  end
endmodule // test_double_slot_keystream_mapper
